// ===== core/cmos_pkg.sv
/*
  Constants shared by the message object status and identifier tag block.
  Assumes an 8-bit special-function register bus and a single 200 MHz clock.
*/
package cmos_pkg;
  // ==========================================================================
  // Geometry
  localparam int unsigned NUM_OBJ = 15;
  localparam int unsigned OBJ_W = 4;
  localparam int unsigned TAG_W = 32;
  localparam int unsigned ID_W = 29;
  localparam logic [3:0] NUM_OBJ_CODE = 4'hf;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ADDR_OBJECT_STATUS = 8'hb2;
  localparam logic [7:0] ADDR_ID_TAG_1 = 8'hbc;
  localparam logic [7:0] ADDR_ID_TAG_2 = 8'hbd;
  localparam logic [7:0] ADDR_ID_TAG_3 = 8'hbe;
  localparam logic [7:0] ADDR_ID_TAG_4 = 8'hbf;

  // ==========================================================================
  // Status field positions
  localparam int unsigned BIT_LENGTH_WARNING = 7;
  localparam int unsigned BIT_TRANSMIT_DONE = 6;
  localparam int unsigned BIT_RECEIVE_DONE = 5;
  localparam int unsigned BIT_BIT_MISMATCH = 4;
  localparam int unsigned BIT_STUFFING = 3;
  localparam int unsigned BIT_CHECKSUM = 2;
  localparam int unsigned BIT_FRAME_FORM = 1;
  localparam int unsigned BIT_ACKNOWLEDGE = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // ==========================================================================
  // Tag field positions within the fourth tag byte
  localparam int unsigned BIT_REMOTE_REQUEST_TAG = 2;
  localparam int unsigned BIT_RESERVED_BIT1_TAG = 1;
  localparam int unsigned BIT_RESERVED_BIT0_TAG = 0;

  // ==========================================================================
  // Bus-level and checksum constants
  localparam logic BUS_DOMINANT = 1'b0;
  localparam logic BUS_RECESSIVE = 1'b1;
  localparam logic [2:0] STUFF_LIMIT = 3'h5;
  localparam logic [2:0] STUFF_FIRST = 3'h1;
  localparam logic [14:0] CRC_POLY = 15'h4599;
  localparam logic [14:0] CRC_INIT = 15'h0000;

  typedef enum logic [1:0] {
    CMOS_FRAME_IDLE = 2'b00,
    CMOS_FRAME_TX = 2'b01,
    CMOS_FRAME_RX = 2'b10
  } cmos_frame_t;
endpackage : cmos_pkg

// ===== core/cmos_mem_if.sv
/*
  Carrier between the status block and its identifier tag store.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface cmos_mem_if;
  logic [cmos_pkg::OBJ_W-1:0] addr;
  logic [3:0] byte_we;
  logic [7:0] wdata;
  logic [cmos_pkg::TAG_W-1:0] rdata;

  modport master (output addr, output byte_we, output wdata, input rdata);
  modport store (input addr, input byte_we, input wdata, output rdata);
endinterface : cmos_mem_if

// ===== core/cmos_tag_mem.sv
/*
  Identifier tag store: one 32-bit word of four tag bytes per message object.
  Assumes software loads each word before use; contents are not reset.
*/
`timescale 1ns/10ps
module cmos_tag_mem (
  input wire logic clk_i,
  cmos_mem_if.store mem
);
  typedef struct packed {
    logic [cmos_pkg::NUM_OBJ-1:0][cmos_pkg::TAG_W-1:0] word;
    logic [cmos_pkg::TAG_W-1:0] rdata;
  } cmos_mem_state_t;

  cmos_mem_state_t st;
  cmos_mem_state_t next_st;

  always_comb begin
    next_st = st;
    for (int b = 0; b < 4; b++) begin
      if (mem.byte_we[b]) begin
        next_st.word[mem.addr][b*8 +: 8] = mem.wdata;
      end
    end
    next_st.rdata = next_st.word[mem.addr];
  end

  // Tags carry no reset value
  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  assign mem.rdata = st.rdata;
endmodule : cmos_tag_mem

// ===== core/cmos_status_tag.sv
/*
  Message object status flags and identifier tag registers of a CAN controller,
  with bit, stuff, checksum, form and acknowledge checking on the bit stream.
  Assumes the protocol engine presents one sampled bus bit per bit_valid_i pulse
  together with field markers, and that all inputs are synchronous to clk_i.
*/
`timescale 1ns/10ps
// Notes on behaviour
// - Set length warning when received length code differs from configured one.
// - Every received frame overwrites the object's length code with the received one.
// - Set transmit done when the object's transmission completes; not set when a hit reception completes in the same cycle.
// - Among objects ready to send, the lowest index goes first.
// - Set receive done when the object's reception completes.
// - Among objects hit by one frame, the lowest index is updated.
// - While transmitting, flag a bit mismatch when read-back differs from sent.
// - No mismatch for recessive-to-dominant bits in arbitration or ack slot, or in error frames.
// - Flag stuffing error on more than five equal consecutive bits.
// - Checksum over destuffed frame; flag error on mismatch with received field.
// - Flag form error when a fixed-form field is violated.
// - Flag acknowledge error when our frame's ack slot stays recessive.
// - Every completion and error flag can raise the interrupt request.
// - Standard mode: first tag byte holds identifier bits 10 to 3.
// - Standard mode: second tag byte bits 7-5 hold identifier bits 2 to 0.
// - Standard mode: third tag byte holds no identifier bits.
// - Standard mode: fourth tag byte holds remote tag bit 2, bit0 tag bit 0.
// - Extended mode: identifier bits 28-5 spread over the first three tag bytes.
// - Extended mode: fourth byte holds id 4-0, remote, bit1 and bit0 tags.
// - Tag registers have no reset value; software loads them first.
// - Reserved tag bits read undefined; software writes them as zero.
// - Extended select picks 11-bit or 29-bit tag layout.
// - Status shows the object chosen by the page object number; tags follow a page change one cycle later.
module cmos_status_tag (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic [3:0] object_number_i,
  input wire logic extended_id_select_i,
  input wire logic [14:0] tx_enable_i,
  input wire logic tx_done_i,
  input wire logic [14:0] rx_hit_i,
  input wire logic rx_done_i,
  input wire logic [3:0] rx_dlc_i,
  input wire logic [3:0] expected_dlc_i,
  input wire logic frame_start_i,
  input wire logic transmitting_i,
  input wire logic bit_valid_i,
  input wire logic bit_sent_i,
  input wire logic bit_seen_i,
  input wire logic arb_field_i,
  input wire logic ack_slot_i,
  input wire logic error_frame_i,
  input wire logic stuff_region_i,
  input wire logic crc_region_i,
  input wire logic crc_check_i,
  input wire logic fixed_field_i,
  output logic [3:0] tx_object_o,
  output logic tx_pending_o,
  output logic dlc_update_o,
  output logic [3:0] dlc_object_o,
  output logic [3:0] dlc_value_o,
  output logic [28:0] selected_id_o,
  output logic status_irq_o
);
  // ==========================================================================
  // Helpers
  function automatic logic [3:0] cmos_lowest(input logic [14:0] vec);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = cmos_pkg::NUM_OBJ - 1; i >= 0; i--) begin
      if (vec[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : cmos_lowest

  function automatic logic [28:0] cmos_tag_to_id(input logic [31:0] tag, input logic ext);
    if (ext) begin
      return {tag[7:0], tag[15:8], tag[23:16], tag[31:27]};
    end
    return {18'h0, tag[7:0], tag[15:13]};
  endfunction : cmos_tag_to_id

  // ==========================================================================
  // State
  typedef struct packed {
    logic [14:0][7:0] status;
    logic [3:0] tx_obj;
    logic tx_pend;
    logic [3:0] frame_obj;
    cmos_pkg::cmos_frame_t frame;
    logic [2:0] stuff_cnt;
    logic last_bit;
    logic [14:0] crc;
    logic dlc_upd;
    logic [3:0] dlc_obj;
    logic [3:0] dlc_val;
    logic [7:0] rdata;
    logic [28:0] sel_id;
    logic irq;
  } cmos_state_t;

  cmos_state_t st;
  cmos_state_t next_st;
  cmos_mem_if mem_bus ();
  logic [7:0] ev;
  logic [3:0] ev_obj;
  logic [3:0] rx_obj;
  logic crc_fb;
  logic [14:0] crc_now;
  logic [31:0] tag_word;
  logic any_flag;

  cmos_tag_mem u_tag_mem (
    .clk_i(clk_i),
    .mem(mem_bus.store)
  );

  // ==========================================================================
  // Tag store access
  // Page selects object
  assign mem_bus.addr = object_number_i;
  assign mem_bus.wdata = sfr_wdata_i;
  assign tag_word = mem_bus.rdata;

  always_comb begin
    mem_bus.byte_we = 4'h0;
    if (sfr_wr_i && object_number_i < cmos_pkg::NUM_OBJ_CODE) begin
      mem_bus.byte_we[0] = sfr_addr_i == cmos_pkg::ADDR_ID_TAG_1;
      mem_bus.byte_we[1] = sfr_addr_i == cmos_pkg::ADDR_ID_TAG_2;
      mem_bus.byte_we[2] = sfr_addr_i == cmos_pkg::ADDR_ID_TAG_3;
      mem_bus.byte_we[3] = sfr_addr_i == cmos_pkg::ADDR_ID_TAG_4;
    end
  end

  // ==========================================================================
  // Event detection
  assign rx_obj = cmos_lowest(rx_hit_i);
  assign crc_fb = bit_seen_i ^ st.crc[14];
  assign crc_now = {st.crc[13:0], 1'b0} ^ (crc_fb ? cmos_pkg::CRC_POLY : cmos_pkg::CRC_INIT);

  always_comb begin
    ev = 8'h00;
    ev_obj = st.frame_obj;
    if (rx_done_i && rx_hit_i != 15'h0000) begin
      ev_obj = rx_obj;
      ev[cmos_pkg::BIT_RECEIVE_DONE] = 1'b1;
      ev[cmos_pkg::BIT_LENGTH_WARNING] = rx_dlc_i != expected_dlc_i;
    end else if (tx_done_i && st.tx_pend) begin
      ev_obj = st.tx_obj;
      ev[cmos_pkg::BIT_TRANSMIT_DONE] = 1'b1;
    end
    if (bit_valid_i) begin
      ev[cmos_pkg::BIT_BIT_MISMATCH] = transmitting_i && bit_sent_i != bit_seen_i && !error_frame_i
        && !((arb_field_i || ack_slot_i) && bit_sent_i == cmos_pkg::BUS_RECESSIVE);
      ev[cmos_pkg::BIT_STUFFING] = stuff_region_i && bit_seen_i == st.last_bit
        && st.stuff_cnt == cmos_pkg::STUFF_LIMIT;
      ev[cmos_pkg::BIT_FRAME_FORM] = fixed_field_i && bit_seen_i == cmos_pkg::BUS_DOMINANT;
      ev[cmos_pkg::BIT_ACKNOWLEDGE] = ack_slot_i && transmitting_i && bit_seen_i == cmos_pkg::BUS_RECESSIVE;
    end
    ev[cmos_pkg::BIT_CHECKSUM] = crc_check_i && st.crc != cmos_pkg::CRC_INIT;
  end

  // ==========================================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.dlc_upd = 1'b0;
    next_st.tx_pend = tx_enable_i != 15'h0000;
    next_st.tx_obj = cmos_lowest(tx_enable_i);
    if (frame_start_i) begin
      next_st.frame = transmitting_i ? cmos_pkg::CMOS_FRAME_TX : cmos_pkg::CMOS_FRAME_RX;
      next_st.frame_obj = transmitting_i ? st.tx_obj : st.frame_obj;
      next_st.crc = cmos_pkg::CRC_INIT;
      next_st.stuff_cnt = 3'h0;
      next_st.last_bit = cmos_pkg::BUS_RECESSIVE;
    end else if (bit_valid_i) begin
      if (stuff_region_i) begin
        next_st.stuff_cnt = (bit_seen_i == st.last_bit) ? st.stuff_cnt + 3'h1 : cmos_pkg::STUFF_FIRST;
        next_st.last_bit = bit_seen_i;
      end
      if (crc_region_i) begin
        next_st.crc = crc_now;
      end
    end
    if (rx_done_i && rx_hit_i != 15'h0000) begin
      next_st.frame_obj = rx_obj;
      next_st.dlc_upd = 1'b1;
      next_st.dlc_obj = rx_obj;
      next_st.dlc_val = rx_dlc_i;
      next_st.frame = cmos_pkg::CMOS_FRAME_IDLE;
    end else if (tx_done_i) begin
      next_st.frame = cmos_pkg::CMOS_FRAME_IDLE;
    end
    if (sfr_wr_i && sfr_addr_i == cmos_pkg::ADDR_OBJECT_STATUS && object_number_i < cmos_pkg::NUM_OBJ_CODE) begin
      next_st.status[object_number_i] = sfr_wdata_i;
    end
    if (ev_obj < cmos_pkg::NUM_OBJ_CODE) begin
      next_st.status[ev_obj] = next_st.status[ev_obj] | ev;
    end
    next_st.irq = next_st.status != '0;
    next_st.sel_id = cmos_tag_to_id(tag_word, extended_id_select_i);
    if (sfr_rd_i) begin
      unique case (sfr_addr_i)
        cmos_pkg::ADDR_OBJECT_STATUS: next_st.rdata = st.status[object_number_i];
        cmos_pkg::ADDR_ID_TAG_1: next_st.rdata = tag_word[7:0];
        cmos_pkg::ADDR_ID_TAG_2: next_st.rdata = tag_word[15:8];
        cmos_pkg::ADDR_ID_TAG_3: next_st.rdata = tag_word[23:16];
        cmos_pkg::ADDR_ID_TAG_4: next_st.rdata = tag_word[31:24];
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
      st.last_bit <= cmos_pkg::BUS_RECESSIVE;
      st.frame <= cmos_pkg::CMOS_FRAME_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  assign sfr_rdata_o = st.rdata;
  assign tx_object_o = st.tx_obj;
  assign tx_pending_o = st.tx_pend;
  assign dlc_update_o = st.dlc_upd;
  assign dlc_object_o = st.dlc_obj;
  assign dlc_value_o = st.dlc_val;
  assign selected_id_o = st.sel_id;
  assign status_irq_o = st.irq;
  assign any_flag = st.status != '0;

  // ==========================================================================
  // Checks
  a_length_warn_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rx_done_i && rx_hit_i != 15'h0000 && rx_dlc_i != expected_dlc_i
    |=> st.status[$past(rx_obj)][cmos_pkg::BIT_LENGTH_WARNING])
    else $error("length warning not set");
  a_dlc_update_value: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rx_done_i && rx_hit_i != 15'h0000 |=> dlc_update_o && dlc_value_o == $past(rx_dlc_i))
    else $error("length code not forwarded");
  a_transmit_done_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tx_done_i && st.tx_pend && !rx_done_i |=> st.status[$past(st.tx_obj)][cmos_pkg::BIT_TRANSMIT_DONE])
    else $error("transmit done not set");
  a_tx_lowest_first: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tx_enable_i != 15'h0000 |=> tx_pending_o && (($past(tx_enable_i) >> tx_object_o) & 15'h0001) == 15'h0001
    && ($past(tx_enable_i) & ((15'h0001 << tx_object_o) - 15'h0001)) == 15'h0000)
    else $error("lowest transmit object not chosen");
  a_rx_lowest_hit: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rx_done_i && rx_hit_i != 15'h0000 |=> (($past(rx_hit_i) >> dlc_object_o) & 15'h0001) == 15'h0001
    && ($past(rx_hit_i) & ((15'h0001 << dlc_object_o) - 15'h0001)) == 15'h0000)
    else $error("lowest hit object not updated");
  a_bit_arb_exempt: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    bit_valid_i && arb_field_i && bit_sent_i == cmos_pkg::BUS_RECESSIVE |-> !ev[cmos_pkg::BIT_BIT_MISMATCH])
    else $error("bit mismatch raised in arbitration");
  a_stuff_six_bits: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ev[cmos_pkg::BIT_STUFFING] |-> $past(st.last_bit) == bit_seen_i && st.stuff_cnt == cmos_pkg::STUFF_LIMIT)
    else $error("stuffing error without six equal bits");
  a_ack_error_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    bit_valid_i && ack_slot_i && transmitting_i && bit_seen_i && st.frame_obj < cmos_pkg::NUM_OBJ_CODE
    && !rx_done_i && !tx_done_i |=> st.status[$past(st.frame_obj)][cmos_pkg::BIT_ACKNOWLEDGE])
    else $error("acknowledge error not set");
  a_irq_follows_flags: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    any_flag |-> status_irq_o)
    else $error("interrupt request missing");
  a_flags_sticky: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    object_number_i < cmos_pkg::NUM_OBJ_CODE && st.status[object_number_i][cmos_pkg::BIT_RECEIVE_DONE]
    && !(sfr_wr_i && sfr_addr_i == cmos_pkg::ADDR_OBJECT_STATUS)
    |=> st.status[$past(object_number_i)][cmos_pkg::BIT_RECEIVE_DONE])
    else $error("status flag dropped without write");

  // ==========================================================================
  // Event checks
  a_receive_done_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rx_done_i && rx_hit_i != 15'h0000 |=> st.status[dlc_object_o][cmos_pkg::BIT_RECEIVE_DONE])
    else $error("receive done not set");
  a_bit_mismatch_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    bit_valid_i && transmitting_i && bit_sent_i != bit_seen_i && !error_frame_i && !arb_field_i
    && !ack_slot_i && st.frame_obj < cmos_pkg::NUM_OBJ_CODE && !rx_done_i && !tx_done_i
    |=> st.status[$past(st.frame_obj)][cmos_pkg::BIT_BIT_MISMATCH])
    else $error("bit mismatch not set");
  a_rx_no_mismatch: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    bit_valid_i && !transmitting_i |-> !ev[cmos_pkg::BIT_BIT_MISMATCH])
    else $error("bit mismatch raised while receiving");
  a_error_frame_exempt: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    bit_valid_i && error_frame_i |-> !ev[cmos_pkg::BIT_BIT_MISMATCH])
    else $error("bit mismatch raised in error frame");
  a_ack_slot_exempt: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    bit_valid_i && ack_slot_i && bit_sent_i == cmos_pkg::BUS_RECESSIVE |-> !ev[cmos_pkg::BIT_BIT_MISMATCH])
    else $error("bit mismatch raised in ack slot");
  a_checksum_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    crc_check_i && st.crc != cmos_pkg::CRC_INIT && st.frame_obj < cmos_pkg::NUM_OBJ_CODE
    && !rx_done_i && !tx_done_i
    |=> st.status[$past(st.frame_obj)][cmos_pkg::BIT_CHECKSUM])
    else $error("checksum error not set");
  a_checksum_clean: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    crc_check_i && st.crc == cmos_pkg::CRC_INIT |-> !ev[cmos_pkg::BIT_CHECKSUM])
    else $error("checksum error on clean residue");
  a_form_error_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    bit_valid_i && fixed_field_i && bit_seen_i == cmos_pkg::BUS_DOMINANT && st.frame_obj < cmos_pkg::NUM_OBJ_CODE
    && !rx_done_i && !tx_done_i |=> st.status[$past(st.frame_obj)][cmos_pkg::BIT_FRAME_FORM])
    else $error("form error not set");
  a_dlc_pulse_single: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !(rx_done_i && rx_hit_i != 15'h0000) |=> !dlc_update_o)
    else $error("length code update without reception");
  a_tx_none_pending: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tx_enable_i == 15'h0000 |=> !tx_pending_o)
    else $error("transmit pending with nothing enabled");

  // ==========================================================================
  // Register checks
  a_status_write_replace: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sfr_wr_i && sfr_addr_i == cmos_pkg::ADDR_OBJECT_STATUS && object_number_i < cmos_pkg::NUM_OBJ_CODE
    && ev == 8'h00 |=> st.status[$past(object_number_i)] == $past(sfr_wdata_i))
    else $error("status write not applied");
  a_status_read_sel: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sfr_rd_i && sfr_addr_i == cmos_pkg::ADDR_OBJECT_STATUS && object_number_i < cmos_pkg::NUM_OBJ_CODE
    |=> sfr_rdata_o == $past(st.status[object_number_i]))
    else $error("status read from wrong object");
  a_page_write_refused: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sfr_wr_i && object_number_i == cmos_pkg::NUM_OBJ_CODE |-> mem_bus.byte_we == 4'h0)
    else $error("tag write with no object selected");
  a_rdata_holds: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !sfr_rd_i |=> $stable(sfr_rdata_o))
    else $error("read data changed without read");
  a_std_id_upper: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !extended_id_select_i |=> selected_id_o[28:11] == 18'h0)
    else $error("standard identifier has upper bits");
endmodule : cmos_status_tag

// ===== sim/cmos_bus_node.sv
/*
  Other nodes on the shared bus, seen as one wired-AND party.
  Assumes the bench raises the drive requests between clock edges.
*/
`timescale 1ns/10ps
module cmos_bus_node (
  input wire logic tx_level_i,
  input wire logic ack_slot_i,
  input wire logic ack_give_i,
  input wire logic drive_dom_i,
  output logic bus_level_o
);
  // ==========================================================================
  // Wire level
  // Dominant wins, ack by request
  assign bus_level_o = tx_level_i & ~(ack_slot_i & ack_give_i) & ~drive_dom_i;
endmodule : cmos_bus_node

// ===== sim/tb_top.sv
/*
  Self-checking bench for the status and identifier tag block.
  Assumes the block's register and event timing as handed over; one clock.
*/
`timescale 1ns/10ps
module tb_top;
  localparam logic [5:0] F_ARB = 6'h20, F_ACK = 6'h10, F_ERR = 6'h08;
  localparam logic [5:0] F_STF = 6'h04, F_CRC = 6'h02, F_FIX = 6'h01;
  logic clk_i = 1'h0, sys_rst_i = 1'h1, sfr_wr_i = 1'h0, sfr_rd_i = 1'h0;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o;
  logic [3:0] object_number_i = 4'h0, rx_dlc_i = 4'h0, expected_dlc_i = 4'h0;
  logic extended_id_select_i = 1'h0, tx_done_i = 1'h0, rx_done_i = 1'h0;
  logic [14:0] tx_enable_i = 15'h0000, rx_hit_i = 15'h0000;
  logic frame_start_i = 1'h0, transmitting_i = 1'h0, bit_valid_i = 1'h0, bit_sent_i = 1'h1;
  logic crc_check_i = 1'h0, ack_give = 1'h0, drive_dom = 1'h0, bit_seen_i;
  logic [5:0] fld = 6'h00;
  logic arb_field_i, ack_slot_i, error_frame_i, stuff_region_i, crc_region_i, fixed_field_i;
  logic [3:0] tx_object_o, dlc_object_o, dlc_value_o;
  logic tx_pending_o, dlc_update_o, status_irq_o;
  logic [28:0] selected_id_o;
  int bad_count = 0;
  int samples_checked = 0;

  assign {arb_field_i, ack_slot_i, error_frame_i, stuff_region_i, crc_region_i, fixed_field_i} = fld;

  cmos_status_tag i_dut (.clk_i, .sys_rst_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o,
    .object_number_i, .extended_id_select_i, .tx_enable_i, .tx_done_i, .rx_hit_i, .rx_done_i, .rx_dlc_i,
    .expected_dlc_i, .frame_start_i, .transmitting_i, .bit_valid_i, .bit_sent_i, .bit_seen_i, .arb_field_i,
    .ack_slot_i, .error_frame_i, .stuff_region_i, .crc_region_i, .crc_check_i, .fixed_field_i, .tx_object_o,
    .tx_pending_o, .dlc_update_o, .dlc_object_o, .dlc_value_o, .selected_id_o, .status_irq_o);

  cmos_bus_node i_node (.tx_level_i(bit_sent_i), .ack_slot_i(ack_slot_i), .ack_give_i(ack_give),
    .drive_dom_i(drive_dom), .bus_level_o(bit_seen_i));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  // ==========================================================================
  // Access and check tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'h1;
    @(negedge clk_i);
    sfr_wr_i = 1'h0;
    @(negedge clk_i);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    sfr_addr_i = a;
    // Tag store needs the page stable one cycle before the read
    @(negedge clk_i);
    sfr_rd_i = 1'h1;
    @(negedge clk_i);
    sfr_rd_i = 1'h0;
    @(negedge clk_i);
    chk({24'h00_0000, sfr_rdata_o}, {24'h00_0000, e});
  endtask : rd_reg

  task automatic send_bit(input logic lvl, input logic [5:0] f);
    bit_sent_i = lvl;
    fld = f;
    bit_valid_i = 1'h1;
    @(negedge clk_i);
  endtask : send_bit

  task automatic bits_off();
    bit_valid_i = 1'h0;
    fld = 6'h00;
    bit_sent_i = 1'h1;
    @(negedge clk_i);
  endtask : bits_off

  task automatic frame(input logic tx);
    transmitting_i = tx;
    frame_start_i = 1'h1;
    @(negedge clk_i);
    frame_start_i = 1'h0;
  endtask : frame

  task automatic rx_frame(input logic [14:0] hit, input logic [3:0] dlc, input logic [3:0] exp);
    rx_hit_i = hit;
    rx_dlc_i = dlc;
    expected_dlc_i = exp;
    rx_done_i = 1'h1;
    @(negedge clk_i);
    rx_done_i = 1'h0;
  endtask : rx_frame

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    close_out();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    sys_rst_i = 1'h0;
    rd_reg(cmos_pkg::ADDR_OBJECT_STATUS, 8'h00);
    rd_reg(8'hb0, 8'h00);
    object_number_i = 4'h2;
    wr_reg(cmos_pkg::ADDR_ID_TAG_1, 8'ha5);
    wr_reg(cmos_pkg::ADDR_ID_TAG_2, 8'hc0);
    wr_reg(cmos_pkg::ADDR_ID_TAG_3, 8'h00);
    wr_reg(cmos_pkg::ADDR_ID_TAG_4, 8'h05);
    rd_reg(cmos_pkg::ADDR_ID_TAG_1, 8'ha5);
    rd_reg(cmos_pkg::ADDR_ID_TAG_2, 8'hc0);
    rd_reg(cmos_pkg::ADDR_ID_TAG_3, 8'h00);
    rd_reg(cmos_pkg::ADDR_ID_TAG_4, 8'h05);
    chk({21'h0, selected_id_o[10:0]}, 32'h0000_052e);
    extended_id_select_i = 1'h1;
    wr_reg(cmos_pkg::ADDR_ID_TAG_2, 8'h3c);
    wr_reg(cmos_pkg::ADDR_ID_TAG_3, 8'h96);
    wr_reg(cmos_pkg::ADDR_ID_TAG_4, 8'h7f);
    rd_reg(cmos_pkg::ADDR_ID_TAG_3, 8'h96);
    chk({3'h0, selected_id_o}, {3'h0, 8'ha5, 8'h3c, 8'h96, 5'h0f});
    object_number_i = 4'h3;
    wr_reg(cmos_pkg::ADDR_ID_TAG_1, 8'h11);
    object_number_i = 4'hf;
    wr_reg(cmos_pkg::ADDR_ID_TAG_1, 8'h77);
    object_number_i = 4'h3;
    rd_reg(cmos_pkg::ADDR_ID_TAG_1, 8'h11);
    object_number_i = 4'h2;
    rd_reg(cmos_pkg::ADDR_ID_TAG_1, 8'ha5);
    // Reception hitting two objects with a length mismatch
    object_number_i = 4'h1;
    rx_frame(15'h0006, 4'h3, 4'h2);
    chk({23'h0, dlc_update_o, dlc_object_o, dlc_value_o}, 32'h0000_0113);
    chk({31'h0, status_irq_o}, 32'h0000_0001);
    @(negedge clk_i);
    chk({31'h0, dlc_update_o}, 32'h0000_0000);
    rd_reg(cmos_pkg::ADDR_OBJECT_STATUS, 8'ha0);
    rd_reg(cmos_pkg::ADDR_OBJECT_STATUS, 8'ha0);
    object_number_i = 4'h2;
    rd_reg(cmos_pkg::ADDR_OBJECT_STATUS, 8'h00);
    object_number_i = 4'h1;
    wr_reg(cmos_pkg::ADDR_OBJECT_STATUS, 8'h00);
    rd_reg(cmos_pkg::ADDR_OBJECT_STATUS, 8'h00);
    chk({31'h0, status_irq_o}, 32'h0000_0000);
    object_number_i = 4'h3;
    rx_frame(15'h0008, 4'h4, 4'h4);
    rd_reg(cmos_pkg::ADDR_OBJECT_STATUS, 8'h20);
    wr_reg(cmos_pkg::ADDR_OBJECT_STATUS, 8'h00);
    // Transmission with exempt and real bit faults
    tx_enable_i = 15'h400c;
    repeat (2) @(negedge clk_i);
    chk({27'h0, tx_pending_o, tx_object_o}, 32'h0000_0012);
    frame(1'h1);
    drive_dom = 1'h1;
    send_bit(1'h1, F_ARB);
    send_bit(1'h1, F_ERR);
    drive_dom = 1'h0;
    ack_give = 1'h1;
    send_bit(1'h1, F_ACK);
    bits_off();
    tx_done_i = 1'h1;
    @(negedge clk_i);
    tx_done_i = 1'h0;
    object_number_i = 4'h2;
    rd_reg(cmos_pkg::ADDR_OBJECT_STATUS, 8'h40);
    drive_dom = 1'h1;
    send_bit(1'h1, 6'h00);
    drive_dom = 1'h0;
    ack_give = 1'h0;
    send_bit(1'h1, F_ACK);
    bits_off();
    rd_reg(cmos_pkg::ADDR_OBJECT_STATUS, 8'h51);
    tx_enable_i = 15'h0000;
    // Receive-side stuffing, checksum and form checks; flags land on the last frame object
    wr_reg(cmos_pkg::ADDR_OBJECT_STATUS, 8'h00);
    frame(1'h0);
    repeat (5) send_bit(1'h0, F_STF);
    send_bit(1'h1, F_STF);
    bits_off();
    rd_reg(cmos_pkg::ADDR_OBJECT_STATUS, 8'h00);
    repeat (6) send_bit(1'h0, F_STF);
    bits_off();
    rd_reg(cmos_pkg::ADDR_OBJECT_STATUS, 8'h08);
    wr_reg(cmos_pkg::ADDR_OBJECT_STATUS, 8'h00);
    for (int n = 0; n < 2; n++) begin
      frame(1'h0);
      send_bit(n[0], F_CRC);
      repeat (7) send_bit(1'h0, F_CRC);
      bits_off();
      crc_check_i = 1'h1;
      @(negedge clk_i);
      crc_check_i = 1'h0;
      rd_reg(cmos_pkg::ADDR_OBJECT_STATUS, n[0] ? 8'h04 : 8'h00);
    end
    wr_reg(cmos_pkg::ADDR_OBJECT_STATUS, 8'h00);
    send_bit(1'h1, F_FIX);
    bits_off();
    rd_reg(cmos_pkg::ADDR_OBJECT_STATUS, 8'h00);
    drive_dom = 1'h1;
    send_bit(1'h1, F_FIX);
    drive_dom = 1'h0;
    bits_off();
    rd_reg(cmos_pkg::ADDR_OBJECT_STATUS, 8'h02);
    close_out();
  end
endmodule : tb_top
